// ---- mcsr_consts.vh ----
// Constants for the media context save/restore block
`ifndef MCSR_CONSTS_VH
`define MCSR_CONSTS_VH
`define MCSR_NUM_DW 16
`define MCSR_DW_IDX_W 4
`define MCSR_DW_CTX_CTRL 4'h0
`define MCSR_DW_RING_HEAD 4'h1
`define MCSR_DW_RING_TAIL 4'h2
`define MCSR_DW_BB_HEAD 4'h3
`define MCSR_DW_BB_STATE 4'h4
`define MCSR_DW_DIR_VALID 4'h5
`define MCSR_DW_RSVD0 4'h6
`define MCSR_DW_PD_BASE 4'h7
`define MCSR_DW_CTX_ID 4'he
`define MCSR_DW_RSVD1 4'hf
// Per dword: saved in normal mode, restored in normal mode, restored under inhibit
`define MCSR_SAVE_MASK 16'h7f1b
`define MCSR_RESTORE_MASK 16'h7fbf
`define MCSR_INHIBIT_MASK 16'h00a7
`define MCSR_POWER_MASK 16'hffff
// Image layout: status page first, register state one page above
`define MCSR_PAGE_BYTES 32'h0000_1000
`define MCSR_RING_CTX_OFS 32'h0000_1000
`define MCSR_CACHELINE_BYTES 32'h0000_0040
`define MCSR_RING_CTX_LINES 32'h0000_0005
`define MCSR_QW_MASK 32'h0000_0007
`define MCSR_QW_BYTES 32'h0000_0008
`define MCSR_ONE 32'h0000_0001
`define MCSR_NO_MASK 16'h0000
// Reset values
`define MCSR_RST_WORD 32'h0000_0000
`define MCSR_RST_BIT 1'b0
`endif

// ---- mcsr_ctx_ctrl.v ----
// Media engine context save/restore selector and batch buffer fetch address logic
// Operation
// - End address names last valid unit, inclusive
// - Batch fetches are unsnooped main memory reads
// - No batch length limit below 4GB
// - Image is status page then register state
// - Ring mode: no save, no restore, except with power context
// - Register state valid with both enables, or with power context
// - Ring head saved, restored, restored under inhibit
// - Ring tail restore only, also under inhibit
// - Batch head not restored under inhibit
// - Batch state not restored under inhibit
// - Directory base restore only, also under inhibit
// - Ring context 4K above base, five lines
// - Status page accesses cacheable, snooped only with exec list enabled
`timescale 1ns/1ps
`default_nettype none
`include "mcsr_consts.vh"

module mcsr_ctx_ctrl (
    input wire clk_i,
    input wire arst_n_i,
    input wire exec_list_en_i,
    input wire per_process_translation_en_i,
    input wire restore_inhibit_i,
    input wire power_ctx_i,
    input wire [31:0] context_image_base_i,
    input wire save_req_i,
    input wire restore_req_i,
    input wire [3:0] dw_idx_i,
    input wire [31:0] img_dw_i,
    input wire [31:0] hw_dw_i,
    input wire bb_start_i,
    input wire [31:0] bb_start_addr_i,
    input wire [31:0] bb_end_addr_i,
    input wire bb_fetch_ready_i,
    output wire save_en_o,
    output wire restore_en_o,
    output wire [31:0] restore_dw_o,
    output wire [31:0] status_page_addr_o,
    output wire [31:0] reg_state_addr_o,
    output wire [31:0] ring_ctx_addr_o,
    output wire [31:0] ring_ctx_end_o,
    output wire status_snoop_o,
    output wire reg_state_valid_o,
    output wire bb_fetch_valid_o,
    output wire [31:0] bb_fetch_addr_o,
    output wire bb_fetch_snoop_o,
    output wire bb_busy_o,
    output wire bb_align_err_o
);

    localparam ST_IDLE = 2'b01;
    localparam ST_FETCH = 2'b10;

    // Selector registers
    reg save_en_reg;
    reg save_en_next;
    reg restore_en_reg;
    reg restore_en_next;
    reg [31:0] restore_dw_reg;
    reg [31:0] restore_dw_next;
    reg [31:0] status_page_addr_reg;
    reg [31:0] status_page_addr_next;
    reg [31:0] reg_state_addr_reg;
    reg [31:0] reg_state_addr_next;
    reg [31:0] ring_ctx_addr_reg;
    reg [31:0] ring_ctx_addr_next;
    reg [31:0] ring_ctx_end_reg;
    reg [31:0] ring_ctx_end_next;
    reg status_snoop_reg;
    reg status_snoop_next;
    reg reg_state_valid_reg;
    reg reg_state_valid_next;
    // Batch fetch registers
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [31:0] bb_end_reg;
    reg [31:0] bb_end_next;
    reg bb_fetch_valid_reg;
    reg bb_fetch_valid_next;
    reg [31:0] bb_fetch_addr_reg;
    reg [31:0] bb_fetch_addr_next;
    reg bb_fetch_snoop_reg;
    reg bb_fetch_snoop_next;
    reg bb_busy_reg;
    reg bb_busy_next;
    reg bb_align_err_reg;
    reg bb_align_err_next;
    wire ctx_valid;
    wire [15:0] save_mask;
    wire [15:0] restore_mask;
    wire dw_saved;
    wire dw_restored;
    wire bb_misaligned;

    function misaligned;
        input [31:0] addr;
        begin
            misaligned = |(addr & `MCSR_QW_MASK);
        end
    endfunction

    // Dwords written to the image; power context overrides scheduling mode
    function [15:0] save_mask_of;
        input valid;
        input power;
        begin
            if (power) begin
                save_mask_of = `MCSR_POWER_MASK;
            end else if (valid) begin
                save_mask_of = `MCSR_SAVE_MASK;
            end else begin
                save_mask_of = `MCSR_NO_MASK;
            end
        end
    endfunction

    // Dwords loaded from the image
    function [15:0] restore_mask_of;
        input valid;
        input power;
        input inhibit;
        begin
            if (power) begin
                restore_mask_of = `MCSR_POWER_MASK;
            end else if (!valid) begin
                restore_mask_of = `MCSR_NO_MASK;
            end else if (inhibit) begin
                restore_mask_of = `MCSR_INHIBIT_MASK;
            end else begin
                restore_mask_of = `MCSR_RESTORE_MASK;
            end
        end
    endfunction

    assign ctx_valid = exec_list_en_i & per_process_translation_en_i;
    assign save_mask = save_mask_of(ctx_valid, power_ctx_i);
    assign restore_mask = restore_mask_of(ctx_valid, power_ctx_i, restore_inhibit_i);
    assign dw_saved = save_req_i & save_mask[dw_idx_i];
    assign dw_restored = restore_req_i & restore_mask[dw_idx_i];
    assign bb_misaligned = misaligned(bb_start_addr_i) | misaligned(bb_end_addr_i);

    always @* begin
        save_en_next = dw_saved;
        restore_en_next = dw_restored;
        // Skipped fields hand back the live hardware value
        restore_dw_next = dw_restored ? img_dw_i : hw_dw_i;
        status_page_addr_next = context_image_base_i;
        reg_state_addr_next = context_image_base_i + `MCSR_PAGE_BYTES;
        ring_ctx_addr_next = context_image_base_i + `MCSR_RING_CTX_OFS;
        ring_ctx_end_next = context_image_base_i + `MCSR_RING_CTX_OFS
            + `MCSR_RING_CTX_LINES * `MCSR_CACHELINE_BYTES - `MCSR_ONE;
        status_snoop_next = exec_list_en_i;
        reg_state_valid_next = ctx_valid | power_ctx_i;
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            save_en_reg <= `MCSR_RST_BIT;
            restore_en_reg <= `MCSR_RST_BIT;
            restore_dw_reg <= `MCSR_RST_WORD;
            status_page_addr_reg <= `MCSR_RST_WORD;
            reg_state_addr_reg <= `MCSR_RST_WORD;
            ring_ctx_addr_reg <= `MCSR_RST_WORD;
            ring_ctx_end_reg <= `MCSR_RST_WORD;
            status_snoop_reg <= `MCSR_RST_BIT;
            reg_state_valid_reg <= `MCSR_RST_BIT;
        end else begin
            save_en_reg <= save_en_next;
            restore_en_reg <= restore_en_next;
            restore_dw_reg <= restore_dw_next;
            status_page_addr_reg <= status_page_addr_next;
            reg_state_addr_reg <= reg_state_addr_next;
            ring_ctx_addr_reg <= ring_ctx_addr_next;
            ring_ctx_end_reg <= ring_ctx_end_next;
            status_snoop_reg <= status_snoop_next;
            reg_state_valid_reg <= reg_state_valid_next;
        end
    end

    always @* begin
        state_next = state_reg;
        bb_end_next = bb_end_reg;
        bb_fetch_valid_next = bb_fetch_valid_reg;
        bb_fetch_addr_next = bb_fetch_addr_reg;
        bb_fetch_snoop_next = 1'b0;
        bb_busy_next = bb_busy_reg;
        bb_align_err_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                bb_align_err_next = bb_start_i & bb_misaligned;
                if (bb_start_i && !bb_misaligned) begin
                    state_next = ST_FETCH;
                    bb_end_next = bb_end_addr_i;
                    bb_fetch_addr_next = bb_start_addr_i;
                    bb_fetch_valid_next = 1'b1;
                    bb_busy_next = 1'b1;
                end
            end
            ST_FETCH: begin
                if (bb_fetch_ready_i) begin
                    // Inclusive end; full 32-bit span, no length cap
                    if (bb_fetch_addr_reg == bb_end_reg) begin
                        state_next = ST_IDLE;
                        bb_fetch_valid_next = 1'b0;
                        bb_busy_next = 1'b0;
                    end else begin
                        bb_fetch_addr_next = bb_fetch_addr_reg + `MCSR_QW_BYTES;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                bb_fetch_valid_next = 1'b0;
                bb_busy_next = 1'b0;
            end
        endcase
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_IDLE;
            bb_end_reg <= `MCSR_RST_WORD;
            bb_fetch_valid_reg <= `MCSR_RST_BIT;
            bb_fetch_addr_reg <= `MCSR_RST_WORD;
            bb_fetch_snoop_reg <= `MCSR_RST_BIT;
            bb_busy_reg <= `MCSR_RST_BIT;
            bb_align_err_reg <= `MCSR_RST_BIT;
        end else begin
            state_reg <= state_next;
            bb_end_reg <= bb_end_next;
            bb_fetch_valid_reg <= bb_fetch_valid_next;
            bb_fetch_addr_reg <= bb_fetch_addr_next;
            bb_fetch_snoop_reg <= bb_fetch_snoop_next;
            bb_busy_reg <= bb_busy_next;
            bb_align_err_reg <= bb_align_err_next;
        end
    end

    // Every output comes straight from a flip-flop
    assign save_en_o = save_en_reg;
    assign restore_en_o = restore_en_reg;
    assign restore_dw_o = restore_dw_reg;
    assign status_page_addr_o = status_page_addr_reg;
    assign reg_state_addr_o = reg_state_addr_reg;
    assign ring_ctx_addr_o = ring_ctx_addr_reg;
    assign ring_ctx_end_o = ring_ctx_end_reg;
    assign status_snoop_o = status_snoop_reg;
    assign reg_state_valid_o = reg_state_valid_reg;
    assign bb_fetch_valid_o = bb_fetch_valid_reg;
    assign bb_fetch_addr_o = bb_fetch_addr_reg;
    assign bb_fetch_snoop_o = bb_fetch_snoop_reg;
    assign bb_busy_o = bb_busy_reg;
    assign bb_align_err_o = bb_align_err_reg;

endmodule // mcsr_ctx_ctrl
`default_nettype wire

// ---- mcsr_ctx_ctrl_properties.sv ----
// Checker for the save/restore selector and the batch fetch sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mcsr_consts.vh"
module mcsr_ctx_ctrl_properties (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic exec_list_en_i,
    input wire logic per_process_translation_en_i,
    input wire logic restore_inhibit_i,
    input wire logic power_ctx_i,
    input wire logic save_req_i,
    input wire logic restore_req_i,
    input wire logic bb_start_i,
    input wire logic bb_fetch_ready_i,
    input wire logic save_en_o,
    input wire logic restore_en_o,
    input wire logic status_snoop_o,
    input wire logic reg_state_valid_o,
    input wire logic bb_fetch_valid_o,
    input wire logic bb_fetch_snoop_o,
    input wire logic bb_busy_o,
    input wire logic bb_align_err_o,
    input wire logic [3:0] dw_idx_i,
    input wire logic [31:0] context_image_base_i,
    input wire logic [31:0] img_dw_i,
    input wire logic [31:0] hw_dw_i,
    input wire logic [31:0] restore_dw_o,
    input wire logic [31:0] status_page_addr_o,
    input wire logic [31:0] reg_state_addr_o,
    input wire logic [31:0] ring_ctx_addr_o,
    input wire logic [31:0] ring_ctx_end_o,
    input wire logic [31:0] bb_start_addr_i,
    input wire logic [31:0] bb_end_addr_i,
    input wire logic [31:0] bb_fetch_addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    wire nm = exec_list_en_i & per_process_translation_en_i;
    wire [15:0] sm = power_ctx_i ? `MCSR_POWER_MASK : nm ? `MCSR_SAVE_MASK : 16'h0000;
    wire [15:0] rm = power_ctx_i ? `MCSR_POWER_MASK : !nm ? 16'h0000 :
        restore_inhibit_i ? `MCSR_INHIBIT_MASK : `MCSR_RESTORE_MASK;
    wire re = restore_req_i & rm[dw_idx_i];
    wire ok = ((bb_start_addr_i | bb_end_addr_i) & 32'h7) == 32'h0;
    wire go = bb_start_i & !bb_busy_o;
    wire st = bb_fetch_valid_o & bb_fetch_ready_i;
    wire last = bb_fetch_addr_o == bb_end_addr_i;
    AST_SAVE: assert property (1 |=> save_en_o == $past(save_req_i & sm[dw_idx_i]))
        else $error("save select wrong");
    AST_RESTORE: assert property (1 |=> restore_en_o == $past(re))
        else $error("restore select wrong");
    AST_DATA: assert property (1 |=> restore_dw_o == $past(re ? img_dw_i : hw_dw_i))
        else $error("restore data wrong");
    AST_LAYOUT: assert property (1 |=>
        reg_state_addr_o == $past(context_image_base_i) + 32'h1000 &&
        ring_ctx_end_o == $past(context_image_base_i) + 32'h113f) else $error("layout");
    AST_BASE: assert property (1 |=>
        status_page_addr_o == $past(context_image_base_i) &&
        ring_ctx_addr_o == $past(context_image_base_i) + 32'h1000) else $error("base wrong");
    AST_STATUS: assert property (1 |=> status_snoop_o == $past(exec_list_en_i) &&
        reg_state_valid_o == $past(nm | power_ctx_i)) else $error("status flags wrong");
    AST_START: assert property (go && ok |=> bb_fetch_valid_o && !bb_fetch_snoop_o &&
        bb_fetch_addr_o == $past(bb_start_addr_i)) else $error("fetch start wrong");
    AST_STEP: assert property (st && !last |=> bb_fetch_valid_o &&
        bb_fetch_addr_o == $past(bb_fetch_addr_o) + 32'h8) else $error("fetch step wrong");
    AST_END: assert property (st && last |=> !bb_fetch_valid_o && !bb_busy_o)
        else $error("fetch did not stop at end");
    AST_ALIGN: assert property (go && !ok |=> bb_align_err_o && !bb_fetch_valid_o)
        else $error("misaligned batch accepted");
    cover property (re && restore_inhibit_i);
    cover property (st && last);
    cover property (go && !ok);
    cover property (power_ctx_i && save_req_i);
endmodule // mcsr_ctx_ctrl_properties
bind mcsr_ctx_ctrl mcsr_ctx_ctrl_properties props (.*);
`default_nettype wire

// ---- mcsr_mem_model.sv ----
// Memory side that accepts batch fetches, every other cycle when slow
`timescale 1ns/1ps
`default_nettype none
module mcsr_mem_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic bb_fetch_valid_o,
    output logic bb_fetch_ready_i,
    output int taken
);
    logic ph = 1'b0;
    initial bb_fetch_ready_i = 1'b0;
    initial taken = 0;
    always @(posedge clk_i) if (bb_fetch_valid_o && bb_fetch_ready_i) taken <= taken + 1;
    always @(negedge clk_i) begin
        ph <= !ph;
        bb_fetch_ready_i <= bb_fetch_valid_o && (!slow_i || ph);
    end
endmodule // mcsr_mem_model
`default_nettype wire

// ---- mcsr_ctx_ctrl_test.sv ----
// Self-checking bench for the context save/restore block
`timescale 1ns/1ps
`default_nettype none
`include "mcsr_consts.vh"
module mcsr_ctx_ctrl_test;
    logic clk_i = 0, arst_n_i = 0, exec_list_en_i = 0, per_process_translation_en_i = 0;
    logic restore_inhibit_i = 0, power_ctx_i = 0, save_req_i = 0, restore_req_i = 0;
    logic bb_start_i = 0, slow = 0, bb_fetch_ready_i;
    logic [3:0] dw_idx_i = 4'h0;
    logic [31:0] context_image_base_i = 32'h23000, img_dw_i = 0, hw_dw_i = 0;
    logic [31:0] bb_start_addr_i = 0, bb_end_addr_i = 0;
    wire save_en_o, restore_en_o, status_snoop_o, reg_state_valid_o, bb_fetch_valid_o;
    wire bb_fetch_snoop_o, bb_busy_o, bb_align_err_o;
    wire [31:0] restore_dw_o, status_page_addr_o, reg_state_addr_o, ring_ctx_addr_o;
    wire [31:0] ring_ctx_end_o, bb_fetch_addr_o;
    int fails = 0, check_count = 0, taken;
    mcsr_ctx_ctrl dut (.*);
    mcsr_mem_model mem (.clk_i(clk_i), .slow_i(slow), .bb_fetch_valid_o(bb_fetch_valid_o),
        .bb_fetch_ready_i(bb_fetch_ready_i), .taken(taken));
    initial forever #5 clk_i = !clk_i;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Every dword offered for save and restore, back to back
    task sel(input logic [3:0] m, input logic [15:0] sv, input logic [15:0] rs);
        {power_ctx_i, restore_inhibit_i, per_process_translation_en_i, exec_list_en_i} = m;
        for (int i = 0; i < 16; i++) begin
            dw_idx_i = i[3:0];
            {save_req_i, restore_req_i} = 2'b11;
            img_dw_i = 32'hc0de0000 | i;
            hw_dw_i = 32'h0bad0000 | i;
            @(negedge clk_i);
            chk({save_en_o, restore_en_o}, {sv[i], rs[i]});
            chk(restore_dw_o, rs[i] ? img_dw_i : hw_dw_i);
            chk({reg_state_valid_o, status_snoop_o}, {(m[0] & m[1]) | m[3], m[0]});
        end
        {save_req_i, restore_req_i} = 2'b00;
    endtask
    task bb(input logic [31:0] s, input logic [31:0] e, input logic sl, input logic err);
        int t0;
        t0 = taken;
        slow = sl;
        {bb_start_addr_i, bb_end_addr_i, bb_start_i} = {s, e, 1'b1};
        @(negedge clk_i);
        bb_start_i = 0;
        chk(bb_align_err_o, err);
        chk(bb_fetch_valid_o, !err);
        if (!err) chk(bb_fetch_addr_o, s);
        for (int n = 0; n < 200 && bb_busy_o === 1'b1; n++) begin
            chk(bb_fetch_snoop_o, 0);
            @(negedge clk_i);
        end
        chk(bb_busy_o, 0);
        if (bb_busy_o !== 1'b0) summarize;
        chk(taken - t0, err ? 0 : (e - s) / 8 + 1);
        if (!err) chk(bb_fetch_addr_o, e);
    endtask
    // Reset in mid-fetch drops every output, then the block starts clean
    task rst_mid;
        {bb_start_addr_i, bb_end_addr_i, bb_start_i} = {32'h500, 32'h5f8, 1'b1};
        @(negedge clk_i);
        bb_start_i = 0;
        @(negedge clk_i);
        arst_n_i = 0;
        #1;
        chk({bb_busy_o, bb_fetch_valid_o, reg_state_valid_o, save_en_o}, 0);
        chk(reg_state_addr_o, 0);
        @(negedge clk_i);
        arst_n_i = 1;
        @(negedge clk_i);
        chk(bb_busy_o, 0);
        chk(reg_state_addr_o, context_image_base_i + `MCSR_PAGE_BYTES);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        arst_n_i = 1;
        @(negedge clk_i);
        chk(reg_state_addr_o, context_image_base_i + `MCSR_PAGE_BYTES);
        chk(ring_ctx_end_o, context_image_base_i + 32'h113f);
        chk(status_page_addr_o, context_image_base_i);
        chk(ring_ctx_addr_o, context_image_base_i + 32'h1000);
        sel(4'b0000, 16'h0, 16'h0);
        sel(4'b0010, 16'h0, 16'h0);
        sel(4'b0001, 16'h0, 16'h0);
        sel(4'b0011, `MCSR_SAVE_MASK, `MCSR_RESTORE_MASK);
        sel(4'b0111, `MCSR_SAVE_MASK, `MCSR_INHIBIT_MASK);
        sel(4'b1111, 16'hffff, 16'hffff);
        sel(4'b1000, 16'hffff, 16'hffff);
        bb(32'h100, 32'h108, 0, 0);
        bb(32'h200, 32'h278, 1, 0);
        bb(32'h304, 32'h318, 0, 1);
        bb(32'h400, 32'h400, 1, 0);
        rst_mid;
        bb(32'h600, 32'h610, 0, 0);
        summarize;
    end
endmodule // mcsr_ctx_ctrl_test
`default_nettype wire
